// ### rtl/scl_pkg.sv
// Purpose: shared constants of the serial configuration loader
// Assumes: link engine counts cycles of the host bus clock
// Notes:   all cycle figures are in link clock cycles
package scl_pkg;
  // ----------------------------------------
  // serial timing, link clock cycles
  // ----------------------------------------
  localparam int SCL_SETUP_CYC  = 70;
  localparam int SCL_SAMPLE_CYC = 70;
  localparam int SCL_PERIOD_CYC = 140;
  localparam int SCL_RISE_CNT   = SCL_SETUP_CYC - 1;
  localparam int SCL_LAST_CNT   = SCL_PERIOD_CYC - 1;
  // ----------------------------------------
  // word format
  // ----------------------------------------
  localparam int       SCL_DATA_BITS  = 16;
  localparam int       SCL_ABITS_S    = 6;
  localparam int       SCL_ABITS_L    = 8;
  localparam int       SCL_RX_W       = 24;
  localparam int       SCL_OP_BITS    = 3;
  localparam logic [2:0] SCL_OPCODE   = 3'h6;
  localparam logic [7:0] SCL_MARKER   = 8'h10;
  localparam int       SCL_MARK_LSB_S = 10;
  localparam logic [7:0] SCL_HEAD_ADDR = 8'h00;
  localparam logic [7:0] SCL_FIRST_WORD = 8'h01;
  localparam logic [7:0] SCL_END_RST  = 8'h00;
endpackage

// ### rtl/scl_link_if.sv
// Purpose: word request and answer between loader and link engine
// Assumes: request fields stay stable between toggle and answer
// Notes:   toggles cross clock domains, words ride alongside
`timescale 1ns/1ps
interface scl_link_if;
  logic        req_tgl;
  logic [7:0]  word_addr;
  logic        wide;
  logic        ack_tgl;
  logic [23:0] rx_word;
  modport ctl (output req_tgl, output word_addr, output wide,
               input ack_tgl, input rx_word);
  modport eng (input req_tgl, input word_addr, input wide,
               output ack_tgl, output rx_word);
endinterface

// ### rtl/scl_word_reader.sv
// Purpose: one serial word read per request, on the link clock
// Assumes: requester holds address and width until answered
// Notes:   lines idle with select low and data released
`timescale 1ns/1ps
module scl_word_reader
  import scl_pkg::*;
(
  // clocks and reset
  input  wire logic pci_clk,
  input  wire logic rst,
  // request side
  scl_link_if.eng   lnk,
  // serial pins
  output logic      cs_ff,
  output logic      sck_ff,
  output logic      dout_ff,
  output logic      doe_ff,
  input  wire logic din
);
  typedef enum logic {SCL_R_IDLE, SCL_R_RUN} scl_rstate_t;
  logic [1:0]  prst_ff;
  logic        prst;
  logic        din1_ff, din2_ff, rq1_ff, rq2_ff;
  scl_rstate_t st_ff, nxt_st;
  logic [7:0]  cnt_ff, nxt_cnt;
  logic [4:0]  idx_ff, nxt_idx;
  logic [7:0]  addr_ff, nxt_addr;
  logic        wide_ff, nxt_wide;
  logic        seen_ff, nxt_seen, ack_ff, nxt_ack;
  logic [23:0] rx_ff, nxt_rx;
  logic        nxt_cs, nxt_sck, nxt_dout, nxt_doe;
  logic [4:0]  last_idx;
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pci_clk or posedge rst)
    if (rst)
      prst_ff <= 2'h3;
    else
      prst_ff <= {prst_ff[0], 1'b0};
  assign prst = prst_ff[1];
  always_ff @(posedge pci_clk or posedge prst)
    if (prst)
    begin
      din1_ff <= 1'b0;
      din2_ff <= 1'b0;
      rq1_ff  <= 1'b0;
      rq2_ff  <= 1'b0;
    end
    else
    begin
      din1_ff <= din;
      din2_ff <= din1_ff;
      rq1_ff  <= lnk.req_tgl;
      rq2_ff  <= rq1_ff;
    end
  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  // bit 0 is the deselect gap, then opcode, address, sixteen data bits
  assign last_idx = wide_ff ? 5'h1b : 5'h19;
  function automatic logic [1:0] drive(input logic [4:0] i, input logic [7:0] a,
                                       input logic w);
    logic [4:0] ab;
    logic [4:0] k;
    ab = w ? 5'h08 : 5'h06;
    k  = ab + 5'h03 - i;
    if (i >= 5'h01 && i <= 5'h03)
      drive = {1'b1, SCL_OPCODE[2'h3 - i[1:0]]};
    else if (i >= 5'h04 && i <= ab + 5'h03)
      drive = {1'b1, a[k[2:0]]};
    else
      drive = 2'h0;
  endfunction
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_idx  = idx_ff;
    nxt_addr = addr_ff;
    nxt_wide = wide_ff;
    nxt_seen = seen_ff;
    nxt_ack  = ack_ff;
    nxt_rx   = rx_ff;
    nxt_cs   = cs_ff;
    nxt_sck  = sck_ff;
    nxt_dout = dout_ff;
    nxt_doe  = doe_ff;
    unique case (st_ff)
      SCL_R_IDLE:
        if (rq2_ff != seen_ff)
        begin
          nxt_seen = rq2_ff;
          nxt_addr = lnk.word_addr;
          nxt_wide = lnk.wide;
          nxt_st   = SCL_R_RUN;
          nxt_cnt  = 8'h00;
          nxt_idx  = 5'h00;
          nxt_cs   = 1'b0; // RULE_17
        end
      SCL_R_RUN:
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == 8'(SCL_RISE_CNT))
          nxt_sck = 1'b1; // RULE_07
        if (cnt_ff == 8'(SCL_LAST_CNT))
        begin
          nxt_cnt = 8'h00;
          nxt_sck = 1'b0;
          if (idx_ff >= 5'h04)
            nxt_rx = {rx_ff[22:0], din2_ff}; // RULE_06
          if (idx_ff == last_idx)
          begin
            nxt_st   = SCL_R_IDLE;
            nxt_cs   = 1'b0; // RULE_17
            nxt_doe  = 1'b0;
            nxt_dout = 1'b0;
            nxt_ack  = ~ack_ff;
          end
          else
          begin
            nxt_idx  = idx_ff + 5'h01;
            nxt_cs   = 1'b1; // RULE_05
            {nxt_doe, nxt_dout} = drive(idx_ff + 5'h01, addr_ff, wide_ff); // RULE_17
          end
        end
      end
    endcase
  end
  always_ff @(posedge pci_clk or posedge prst)
    if (prst)
    begin
      st_ff   <= SCL_R_IDLE;
      cnt_ff  <= 8'h00;
      idx_ff  <= 5'h00;
      addr_ff <= 8'h00;
      wide_ff <= 1'b1;
      seen_ff <= 1'b0;
      ack_ff  <= 1'b0;
      rx_ff   <= 24'h000000;
      cs_ff   <= 1'b0;
      sck_ff  <= 1'b0;
      dout_ff <= 1'b0;
      doe_ff  <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      idx_ff  <= nxt_idx;
      addr_ff <= nxt_addr;
      wide_ff <= nxt_wide;
      seen_ff <= nxt_seen;
      ack_ff  <= nxt_ack;
      rx_ff   <= nxt_rx;
      cs_ff   <= nxt_cs;
      sck_ff  <= nxt_sck;
      dout_ff <= nxt_dout;
      doe_ff  <= nxt_doe;
    end
  assign lnk.ack_tgl = ack_ff;
  assign lnk.rx_word = rx_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pci_clk); endclocking
  default disable iff (prst);
  sequence s_bit_start;
    st_ff == SCL_R_RUN && cnt_ff == 8'(SCL_LAST_CNT) && idx_ff != last_idx;
  endsequence
  // setup shows one edge after s_bit_start, the rise 70 edges after that
  a_setup_rise: assert property (s_bit_start |=> ##70 $rose(sck_ff)) // RULE_05
    else $error("serial clock rise not 70 cycles after setup");
  a_sample_fall: assert property ($rose(sck_ff) |-> ##70 $fell(sck_ff)) // RULE_06
    else $error("sample point not 70 cycles after rise");
  a_period_len: assert property ($rose(sck_ff) && idx_ff != last_idx
    |-> ##140 $rose(sck_ff)) // RULE_07
    else $error("serial clock period is not 140 cycles");
  a_gap_desel: assert property ($changed(ack_ff) |-> !cs_ff && !doe_ff) // RULE_17
    else $error("select or data still driven after a word");
endmodule

// ### rtl/scl_loader.sv
// Purpose: loads internal registers from a serial configuration memory
// Assumes: rst is the host bus reset; pci_clk is the host bus clock
// Notes:   internal bus writes leave on clk, one pulse per load word
//
// Function
// (RULE_01) every release of host reset starts a fresh configuration load
// (RULE_02) memory returns 16-bit words over one shared data line
// (RULE_03) memories with six or eight address bits work unconfigured
// (RULE_04) each word is fetched by its own read command
// (RULE_05) select and data change 70 link cycles before clock rise
// (RULE_06) incoming data is sampled 70 link cycles after clock rise
// (RULE_07) one serial clock period is 140 link clock cycles
// (RULE_08) word zero upper byte holds marker 00010000
// (RULE_09) first read of word zero finds the address width from marker
// (RULE_10) second read of word zero latches its low byte as end address
// (RULE_11) words one to end address are read in order, then stop
// (RULE_12) upper byte is register address, lower byte is the value
// (RULE_13) each load word gives one internal bus write
// (RULE_14) word zero low byte counts the register writes
// (RULE_15) writes may reach any internal address, identity and enable ranges
// (RULE_16) image unlocks, indexes, writes, restores and relocks indexed registers
// (RULE_17) select drops between words; opcode, address, then sixteen bits msb first
// (RULE_18) bus hold stays until the last write, then lines idle until reset
`timescale 1ns/1ps
module scl_loader
  import scl_pkg::*;
(
  // clocks and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pci_clk,
  // serial memory pins
  output logic            eeprom_chip_select,
  output logic            eeprom_serial_clock,
  output logic            eeprom_data_line_o,
  output logic            eeprom_data_line_oe,
  input  wire logic       eeprom_data_line_i,
  // internal register bus
  output logic            ibus_wr,
  output logic [7:0]      ibus_addr,
  output logic [7:0]      ibus_data,
  output logic            ibus_hold
);
  typedef enum logic [2:0]
  {
    SCL_DISC,
    SCL_WAIT_DISC,
    SCL_HEAD,
    SCL_WAIT_HEAD,
    SCL_LOAD,
    SCL_WAIT_LOAD,
    SCL_IDLE
  } scl_state_t;

  scl_link_if lnk ();

  scl_state_t  st_ff, nxt_st;
  logic        req_ff, nxt_req;
  logic [7:0]  waddr_ff, nxt_waddr;
  logic        wide_ff, nxt_wide;
  logic [7:0]  end_ff, nxt_end;
  logic        ack1_ff, ack2_ff, ack_seen_ff;
  logic        ack_ev;
  logic        wr_ff, nxt_wr;
  logic [7:0]  wa_ff, nxt_wa;
  logic [7:0]  wd_ff, nxt_wd;
  logic        busy_ff, nxt_busy;
  logic [15:0] word;

  // ----------------------------------------
  // link engine on the host bus clock
  // ----------------------------------------
  scl_word_reader u_reader
  (
    .pci_clk (pci_clk),
    .rst     (rst),
    .lnk     (lnk.eng),
    .cs_ff   (eeprom_chip_select),
    .sck_ff  (eeprom_serial_clock),
    .dout_ff (eeprom_data_line_o),
    .doe_ff  (eeprom_data_line_oe),
    .din     (eeprom_data_line_i)
  );

  assign lnk.req_tgl   = req_ff;
  assign lnk.word_addr = waddr_ff;
  assign lnk.wide      = wide_ff;

  // ----------------------------------------
  // answer crossing
  // ----------------------------------------
  // rx_word is quiet once the toggle is seen, so it is read directly
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ack1_ff     <= 1'b0;
      ack2_ff     <= 1'b0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      ack1_ff     <= lnk.ack_tgl;
      ack2_ff     <= ack1_ff;
      ack_seen_ff <= ack2_ff;
    end
  assign ack_ev = ack2_ff != ack_seen_ff;
  assign word   = lnk.rx_word[SCL_DATA_BITS-1:0]; // RULE_02

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_req   = req_ff;
    nxt_waddr = waddr_ff;
    nxt_wide  = wide_ff;
    nxt_end   = end_ff;
    nxt_wr    = 1'b0;
    nxt_wa    = wa_ff;
    nxt_wd    = wd_ff;
    nxt_busy  = busy_ff;
    unique case (st_ff)
      SCL_DISC:
      begin
        // probe with the longer width and look for the marker
        nxt_waddr = SCL_HEAD_ADDR;
        nxt_wide  = 1'b1;
        nxt_req   = ~req_ff; // RULE_01
        nxt_st    = SCL_WAIT_DISC;
      end
      SCL_WAIT_DISC:
        if (ack_ev)
        begin
          // short parts put the marker two slots earlier
          nxt_wide = lnk.rx_word[SCL_MARK_LSB_S +: 8] != SCL_MARKER; // RULE_03 RULE_08 RULE_09
          nxt_st   = SCL_HEAD;
        end
      SCL_HEAD:
      begin
        nxt_waddr = SCL_HEAD_ADDR;
        nxt_req   = ~req_ff; // RULE_04
        nxt_st    = SCL_WAIT_HEAD;
      end
      SCL_WAIT_HEAD:
        if (ack_ev)
        begin
          nxt_end   = word[7:0]; // RULE_10 RULE_14
          nxt_waddr = SCL_FIRST_WORD;
          nxt_st    = (word[7:0] == SCL_END_RST) ? SCL_IDLE : SCL_LOAD;
        end
      SCL_LOAD:
      begin
        nxt_req = ~req_ff; // RULE_04
        nxt_st  = SCL_WAIT_LOAD;
      end
      SCL_WAIT_LOAD:
        if (ack_ev)
        begin
          nxt_wr = 1'b1; // RULE_13
          nxt_wa = word[15:8]; // RULE_12 RULE_15
          nxt_wd = word[7:0]; // RULE_12
          if (waddr_ff == end_ff)
            nxt_st = SCL_IDLE; // RULE_11
          else
          begin
            nxt_waddr = waddr_ff + 8'h01; // RULE_11
            nxt_st    = SCL_LOAD;
          end
        end
      SCL_IDLE:
        nxt_busy = 1'b0; // RULE_18
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st_ff    <= SCL_DISC;
      req_ff   <= 1'b0;
      waddr_ff <= SCL_HEAD_ADDR;
      wide_ff  <= 1'b1;
      end_ff   <= SCL_END_RST;
      wr_ff    <= 1'b0;
      wa_ff    <= 8'h00;
      wd_ff    <= 8'h00;
      busy_ff  <= 1'b1;
    end
    else
    begin
      st_ff    <= nxt_st;
      req_ff   <= nxt_req;
      waddr_ff <= nxt_waddr;
      wide_ff  <= nxt_wide;
      end_ff   <= nxt_end;
      wr_ff    <= nxt_wr;
      wa_ff    <= nxt_wa;
      wd_ff    <= nxt_wd;
      busy_ff  <= nxt_busy;
    end

  assign ibus_wr   = wr_ff;
  assign ibus_addr = wa_ff;
  assign ibus_data = wd_ff;
  assign ibus_hold = busy_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_word;
    st_ff == SCL_WAIT_LOAD && ack_ev && waddr_ff == end_ff;
  endsequence
  sequence s_release;
    wr_ff && st_ff == SCL_IDLE ##1 !busy_ff;
  endsequence

  a_start_load: assert property ($fell(rst) |-> st_ff == SCL_DISC ##1 $changed(req_ff)) // RULE_01
    else $error("load did not start after reset release");
  a_width_held: assert property (st_ff != SCL_WAIT_DISC |=> $stable(wide_ff)) // RULE_09
    else $error("address width changed after discovery");
  a_head_reread: assert property (st_ff == SCL_WAIT_DISC && ack_ev |=> st_ff == SCL_HEAD
    ##1 $changed(req_ff) && waddr_ff == SCL_HEAD_ADDR) // RULE_10
    else $error("word zero not read again after discovery");
  a_one_cmd: assert property (st_ff == SCL_LOAD |=> $changed(req_ff)
    ##1 $stable(req_ff)) // RULE_04
    else $error("load word without its own read command");
  a_addr_step: assert property (st_ff == SCL_WAIT_LOAD && ack_ev && waddr_ff != end_ff
    |=> waddr_ff == $past(waddr_ff) + 8'h01) // RULE_11
    else $error("load words not read in ascending order");
  a_wr_fields: assert property (st_ff == SCL_WAIT_LOAD && ack_ev
    |=> wr_ff && ibus_addr == $past(word[15:8]) && ibus_data == $past(word[7:0])) // RULE_12
    else $error("write does not carry the word bytes");
  a_wr_pulse: assert property (wr_ff |=> !wr_ff) // RULE_13
    else $error("internal write longer than one cycle");
  a_stop_end: assert property (s_last_word |=> s_release) // RULE_18
    else $error("loader did not stop and release after the last word");
  a_hold_busy: assert property (st_ff != SCL_IDLE |-> busy_ff) // RULE_18
    else $error("bus hold dropped during the load");
  a_idle_stay: assert property (st_ff == SCL_IDLE |=> st_ff == SCL_IDLE && !wr_ff) // RULE_11
    else $error("activity after the load finished");
endmodule

// ### test/scl_eeprom_model.sv
// Purpose: behavioural three-wire serial memory with 16-bit words
// Assumes: pins are sampled on the link clock, one cycle after they move
// Notes:   bad is sticky and flags timing or command faults
`timescale 1ns/1ps
module scl_eeprom_model
(
  // clock and reset
  input  wire logic       pci_clk,
  input  wire logic       rst,
  // pins
  input  wire logic       cs,
  input  wire logic       sck,
  input  wire logic       din,
  output logic            dout,
  output logic            doe,
  // setup and status
  input  wire logic [3:0] abits,
  output logic [7:0]      nreads,
  output logic            bad
);
  logic [15:0] mem [256];
  logic [15:0] w;
  logic [7:0]  addr;
  logic [2:0]  op;
  logic        cs_q;
  logic        sck_q;
  logic        first;
  int          cnt;
  int          r;
  initial
  begin
    {dout, doe, nreads, bad, cs_q, sck_q, first, cnt, r, w, addr, op} = '0;
  end
  always @(posedge pci_clk)
  begin
    cs_q  <= cs;
    sck_q <= sck;
    cnt   <= cnt + 1;
    if (rst)
    begin
      {nreads, bad, doe, r} <= '0;
    end
    else if (!cs)
    begin
      doe <= 1'b0;
      r   <= 0;
    end
    else
    begin
      if (!cs_q)
      begin
        cnt   <= 1;
        first <= 1'b1;
      end
      if (sck && !sck_q)
      begin
        if (cnt != (first ? 70 : 140))
          bad <= 1'b1;
        cnt   <= 1;
        first <= 1'b0;
        r     <= r + 1;
        if (r < 3)
          op <= {op[1:0], din};
        else if (r < 3 + abits)
          addr <= {addr[6:0], din};
        if (r == 2 + abits)
        begin
          if (op != 3'h6)
            bad <= 1'b1;
          nreads <= nreads + 8'h01;
          w    <= mem[{addr[6:0], din} & (abits == 6 ? 8'h3f : 8'hff)];
          doe  <= 1'b1;
          dout <= 1'b0;
        end
        else if (r >= 3 + abits && r < 19 + abits)
        begin
          dout <= w[15];
          w    <= {w[14:0], 1'b0};
        end
        else if (r >= 19 + abits)
          doe <= 1'b0;
      end
    end
  end
endmodule

// ### test/scl_loader_tb_top.sv
// Purpose: self-checking bench of the serial configuration loader
// Assumes: memory model answers on the shared line; link clock free
// Notes:   a released line shows the inverse of its last level
`timescale 1ns/1ps
module scl_loader_tb_top;
  import scl_pkg::*;
  logic        clk = 1'b0;
  logic        pci_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs;
  logic        sck;
  logic        d_o;
  logic        d_oe;
  logic        line;
  logic        line_q = 1'b0;
  logic        m_o;
  logic        m_oe;
  logic [3:0]  abits = 4'h8;
  logic [7:0]  nreads;
  logic        bad;
  logic        wr;
  logic [7:0]  waddr;
  logic [7:0]  wdata;
  logic        hold;
  logic [15:0] img [256];
  logic [31:0] seed = 32'hc61f7483;
  int          widx = 0;
  int          fail_count = 0;
  int          check_count = 0;
  always #10 clk = ~clk;
  initial
  begin
    #1.3;
    forever #3 pci_clk = ~pci_clk;
  end
  // contention while both sides drive the line is settled by giving the loader's driver priority
  assign line = d_oe ? d_o : (m_oe ? m_o : ~line_q);
  always @(posedge pci_clk) line_q <= line;
  scl_loader dut (.clk(clk), .rst(rst), .pci_clk(pci_clk), .eeprom_chip_select(cs),
    .eeprom_serial_clock(sck), .eeprom_data_line_o(d_o), .eeprom_data_line_oe(d_oe),
    .eeprom_data_line_i(line), .ibus_wr(wr), .ibus_addr(waddr), .ibus_data(wdata),
    .ibus_hold(hold));
  scl_eeprom_model mdl (.pci_clk(pci_clk), .rst(rst), .cs(cs), .sck(sck), .din(d_o),
    .dout(m_o), .doe(m_oe), .abits(abits), .nreads(nreads), .bad(bad));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // write monitor
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (rst === 1'b0 && wr === 1'b1)
    begin
      widx++;
      chk("ibus_addr", waddr, {8'h00, img[widx][15:8]});
      chk("ibus_data", wdata, {8'h00, img[widx][7:0]});
      chk("ibus_hold", hold, 16'h1);
    end
  end
  // ----------------------------------------
  // one load: fixed selects the identity and enable addresses
  // ----------------------------------------
  task automatic run(input int ab, input int n, input bit fixed, input bit abort);
    logic [7:0] fx [5];
    int         k;
    fx = '{8'h00, 8'h19, 8'h40, 8'h41, 8'h4c};
    @(posedge clk);
    rst   <= 1'b1;
    abits <= ab[3:0];
    img[0] = {SCL_MARKER, n[7:0]};
    for (int i = 1; i < 256; i++)
    begin
      seed   = lfsr(seed);
      img[i] = seed[15:0];
      if (fixed && i <= 5)
        img[i][15:8] = fx[i-1];
    end
    for (int i = 0; i < 256; i++)
      mdl.mem[i] = img[i];
    repeat (4) @(posedge clk);
    chk("hold_in_reset", hold, 16'h1);
    widx = 0;
    rst <= 1'b0;
    k = 0;
    while (k < (n + 2) * 1500 + 500 && (abort ? widx == 0 : hold !== 1'b0))
    begin
      @(posedge clk);
      k++;
    end
    chk("load_in_time", {15'h0000, k < (n + 2) * 1500 + 500}, 16'h1);
    if (!abort)
    begin
      repeat (300) @(posedge clk);
      chk("write_count", widx[15:0], n[15:0]);
      chk("read_count", {8'h00, nreads}, n[15:0] + 16'h2);
      chk("timing_fault", bad, 16'h0);
      chk("idle_lines", {cs, sck, d_oe, hold}, 16'h0);
      chk("final_write", {waddr, wdata}, n == 0 ? 16'h0 : img[n]);
    end
    $display("test done abits %0d words %0d abort %0d", ab, n, abort);
  endtask
  initial
  begin
    // about two and a half times the expected run, and above the summed cycle budgets
    #1500us;
    fail_count++;
    stop_test();
  end
  initial
  begin
    run(8, 5, 1'b1, 1'b0);
    run(6, 3, 1'b0, 1'b0);
    run(8, 0, 1'b0, 1'b0);
    run(6, 1, 1'b1, 1'b0);
    run(8, 3, 1'b0, 1'b1);
    run(8, 2, 1'b0, 1'b0);
    stop_test();
  end
endmodule
